/* File: logic/fcs_regs.vh */
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// bit timing: 40 MHz / 500 kbit/s = 80 clocks per bit
`define FCS_BIT_CLKS        8'd80
`define FCS_SAMPLE_POINT    8'd56
// identifier field layout: group 2 messages are 10 bbbbbb fff
`define FCS_GRP2_TAG        2'b10
`define FCS_FN_POLL_REQ     3'h5
`define FCS_FN_IO_RESP      3'h3
`define FCS_FN_EXPL_REQ     3'h4
`define FCS_FN_EXPL_RESP    3'h3
`define FCS_FN_DUP_CHECK    3'h7
`define FCS_FN_UNCONN_REQ   3'h6
// io producer modes
`define FCS_MODE_POLL       2'h0
`define FCS_MODE_COS        2'h1
`define FCS_MODE_CYCLIC     2'h2
// error counting
`define FCS_TEC_STEP        9'd8
`define FCS_BUS_OFF_LIMIT   9'd256
// eleven recessive bits mark an idle bus
`define FCS_IDLE_BITS       4'd11
`endif

/* File: logic/fcs_node.v */
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_node #(
  parameter DATA_W = 8
) (
  input  wire              CLK_SYS_I,
  input  wire              RESET_N_I,
  input  wire              CAN_RX_I,
  output wire              CAN_TX_O,
  input  wire [5:0]        NODE_ADDRESS_I,
  input  wire [1:0]        IO_MODE_I,
  input  wire [15:0]       IO_PERIOD_BITS_I,
  input  wire [DATA_W-1:0] IO_DATA_I,
  output wire              RX_VALID_O,
  input  wire              RX_READY_I,
  output wire [10:0]       RX_ID_O,
  output wire [DATA_W-1:0] RX_DATA_O,
  output reg               CONNECTED_O,
  output reg               DUP_ADDRESS_O,
  output reg               BUS_OFF_O,
  output reg               STATUS_EVENT_O
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ARB  = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_RX   = 2'd3;
  localparam FRM_W   = 11 + DATA_W + 2;

  function [10:0] grp2_id;
    input [5:0] addr;
    input [2:0] fn;
    grp2_id = {`FCS_GRP2_TAG, addr, fn};
  endfunction

  function own_frame;
    input [10:0] id;
    input [5:0]  addr;
    input [2:0]  fn;
    own_frame = (id == grp2_id(addr, fn));
  endfunction

  // two-flop synchroniser on the bus input
  reg rx_m_q;
  reg rx_s_q;
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= CAN_RX_I;
      rx_s_q <= rx_m_q;
    end
  end

  // bit timing; there is no resync inside a frame, so both ends must run
  // close to the same bit rate for the whole frame
  reg  [1:0] st_q;
  reg  [7:0] bt_q;
  reg        rx_prev_q;
  wire       sample  = (bt_q == `FCS_SAMPLE_POINT);
  wire       bit_end = (bt_q == `FCS_BIT_CLKS - 8'd1);
  // a falling edge seen while idle restarts the bit, so the sample point
  // lands inside a foreign sender's bit whatever its phase
  wire       hard_sync = (st_q == ST_IDLE) && rx_prev_q && !rx_s_q && !sample;
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bt_q      <= 8'h00;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_s_q;
      if (hard_sync || bit_end)
        bt_q <= 8'h00;
      else
        bt_q <= bt_q + 8'h01;
    end
  end

  reg  [3:0]       idle_q;
  reg  [4:0]       cnt_q;
  reg  [FRM_W-1:0] tx_sr_q;
  reg  [FRM_W-1:0] rx_sr_q;
  reg              tx_bit_q;
  reg  [8:0]       tec_q;
  reg              tx_pend_q;
  reg  [10:0]      tx_id_q;
  reg  [DATA_W-1:0] tx_dat_q;
  reg  [15:0]      tmr_q;
  reg  [DATA_W-1:0] last_q;
  reg              dup_wait_q;
  // dominant is 0: the pin is recessive unless we drive a zero
  assign CAN_TX_O = BUS_OFF_O | tx_bit_q;
  wire bus_bit = rx_s_q; // wired-AND already resolved on the line
  wire bus_idle = (idle_q == `FCS_IDLE_BITS);

  // received frame decode: {ide, id, data, rtr}; the last bit comes
  // straight from the bus so the word is whole at the final sample
  wire [FRM_W-1:0]  rx_frm = {rx_sr_q[FRM_W-2:0], bus_bit};
  wire [10:0]       rx_id  = rx_frm[FRM_W-2 -: 11];
  wire [DATA_W-1:0] rx_dat = rx_frm[DATA_W:1];
  wire              rx_ide = rx_frm[FRM_W-1];
  wire              rx_rtr = rx_frm[0];
  wire              rx_done = (st_q == ST_RX) && sample && (cnt_q == FRM_W - 1);
  // extended and remote frames are dropped
  wire rx_ok = rx_done && !rx_ide && !rx_rtr;
  wire poll_hit = rx_ok && own_frame(rx_id, NODE_ADDRESS_I, `FCS_FN_POLL_REQ);
  wire open_hit = rx_ok && own_frame(rx_id, NODE_ADDRESS_I, `FCS_FN_UNCONN_REQ);
  wire dup_hit  = rx_ok && own_frame(rx_id, NODE_ADDRESS_I, `FCS_FN_DUP_CHECK);

  // frame engine
  wire arb_lost = (st_q == ST_ARB) && sample && tx_bit_q && !bus_bit;
  wire bit_err  = (st_q == ST_DATA) && sample && (tx_bit_q != bus_bit);
  wire tx_done  = (st_q == ST_DATA) && sample && (cnt_q == FRM_W - 1) && !bit_err;
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q     <= ST_IDLE;
      idle_q   <= 4'h0;
      cnt_q    <= 5'h00;
      tx_sr_q  <= {FRM_W{1'b1}};
      rx_sr_q  <= {FRM_W{1'b0}};
      tx_bit_q <= 1'b1;
    end else if (sample) begin
      if (bus_bit && idle_q != `FCS_IDLE_BITS)
        idle_q <= idle_q + 4'h1;
      else if (!bus_bit)
        idle_q <= 4'h0;
      case (st_q)
        ST_IDLE: begin
          tx_bit_q <= 1'b1;
          if (tx_pend_q && bus_idle && !BUS_OFF_O) begin
            st_q     <= ST_ARB;
            cnt_q    <= 5'h00;
            // data frame: ide=0, id, data, rtr=0
            tx_sr_q  <= {1'b0, tx_id_q, tx_dat_q, 1'b0};
            tx_bit_q <= 1'b0;
          end else if (!bus_bit && !BUS_OFF_O) begin
            // the start sample already holds the first frame bit
            st_q    <= ST_RX;
            cnt_q   <= 5'h01;
            rx_sr_q <= {rx_sr_q[FRM_W-2:0], bus_bit};
          end
        end
        ST_ARB: begin
          rx_sr_q <= {rx_sr_q[FRM_W-2:0], bus_bit};
          if (arb_lost) begin
            // withdraw recessive and keep receiving the winner
            st_q     <= ST_RX;
            tx_bit_q <= 1'b1;
          end else begin
            tx_sr_q  <= {tx_sr_q[FRM_W-2:0], 1'b1};
            tx_bit_q <= tx_sr_q[FRM_W-2];
            if (cnt_q == 5'd11)
              st_q <= ST_DATA;
          end
          cnt_q <= cnt_q + 5'h01;
        end
        ST_DATA: begin
          // a mismatch on any own bit ends the frame at once; it stays
          // pending and goes again once the bus is idle
          tx_sr_q  <= {tx_sr_q[FRM_W-2:0], 1'b1};
          tx_bit_q <= tx_sr_q[FRM_W-2];
          cnt_q    <= cnt_q + 5'h01;
          if (bit_err || tx_done) begin
            st_q     <= ST_IDLE;
            tx_bit_q <= 1'b1;
          end
        end
        ST_RX: begin
          rx_sr_q <= {rx_sr_q[FRM_W-2:0], bus_bit};
          cnt_q   <= cnt_q + 5'h01;
          if (cnt_q == FRM_W - 1 || BUS_OFF_O)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // producer: poll answer, change of state, cyclic, explicit answer
  // the producer timer counts whole bit times; zero means expired
  wire tick     = bit_end;
  wire tmr_exp  = (tmr_q == 16'h0000);
  wire changed  = (IO_DATA_I != last_q);
  wire cos_send = CONNECTED_O && (IO_MODE_I == `FCS_MODE_COS) && (changed || tmr_exp);
  wire cyc_send = CONNECTED_O && (IO_MODE_I == `FCS_MODE_CYCLIC) && tmr_exp;
  // bit-strobe requests never match: mode 3 is not served
  wire poll_send = CONNECTED_O && (IO_MODE_I == `FCS_MODE_POLL) && poll_hit;
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_pend_q   <= 1'b0;
      tx_id_q     <= 11'h7ff;
      tx_dat_q    <= {DATA_W{1'b0}};
      tmr_q       <= 16'h0000;
      last_q      <= {DATA_W{1'b0}};
      CONNECTED_O <= 1'b0;
    end else begin
      if (tick && !tmr_exp)
        tmr_q <= tmr_q - 16'h0001;
      if (open_hit)
        CONNECTED_O <= 1'b1;
      if (BUS_OFF_O)
        tx_pend_q <= 1'b0;
      else if (tx_done)
        tx_pend_q <= 1'b0;
      else if (!tx_pend_q) begin
        // one frame waits at a time; a poll arriving meanwhile is lost,
        // while change and cyclic requests stay true and retry
        if (open_hit) begin
          tx_pend_q <= 1'b1;
          // explicit answer sits above io ids numerically
          tx_id_q   <= grp2_id(NODE_ADDRESS_I, `FCS_FN_EXPL_RESP);
          tx_dat_q  <= {DATA_W{1'b0}};
        end else if (poll_send || cos_send || cyc_send) begin
          tx_pend_q <= 1'b1;
          tx_id_q   <= {1'b0, 1'b1, NODE_ADDRESS_I, `FCS_FN_IO_RESP};
          tx_dat_q  <= IO_DATA_I;
          last_q    <= IO_DATA_I;
          tmr_q     <= IO_PERIOD_BITS_I;
        end
      end
    end
  end

  // error counting, duplicate address, status
  wire ev_dup = dup_hit & dup_wait_q;
  wire ev_off = (tec_q >= `FCS_BUS_OFF_LIMIT) & ~BUS_OFF_O;
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tec_q          <= 9'h000;
      BUS_OFF_O      <= 1'b0;
      DUP_ADDRESS_O  <= 1'b0;
      dup_wait_q     <= 1'b1;
      STATUS_EVENT_O <= 1'b0;
    end else begin
      // one bit error weighs as much as eight good frames
      if (bit_err && !BUS_OFF_O)
        tec_q <= tec_q + `FCS_TEC_STEP;
      else if (tx_done && tec_q != 9'h000)
        tec_q <= tec_q - 9'h001;
      if (tec_q >= `FCS_BUS_OFF_LIMIT)
        BUS_OFF_O <= 1'b1;
      if (ev_dup)
        DUP_ADDRESS_O <= 1'b1;
      if (open_hit)
        dup_wait_q <= 1'b0;
      STATUS_EVENT_O <= bit_err | ev_dup | ev_off;
    end
  end

  // two-entry skid buffer toward the host
  // a frame arriving while both entries are full is lost
  reg [11+DATA_W-1:0] buf_q [0:1];
  reg [1:0]           cnt_b_q;
  reg                 wr_q;
  reg                 rd_q;
  wire in_ok  = rx_ok && (cnt_b_q != 2'd2);
  wire out_ok = RX_READY_I && (cnt_b_q != 2'd0);
  assign RX_VALID_O = (cnt_b_q != 2'd0);
  assign RX_ID_O    = buf_q[rd_q][11+DATA_W-1:DATA_W];
  assign RX_DATA_O  = buf_q[rd_q][DATA_W-1:0];
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cnt_b_q  <= 2'd0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      buf_q[0] <= {(11+DATA_W){1'b0}};
      buf_q[1] <= {(11+DATA_W){1'b0}};
    end else begin
      if (in_ok) begin
        buf_q[wr_q] <= {rx_id, rx_dat};
        wr_q        <= ~wr_q;
      end
      if (out_ok)
        rd_q <= ~rd_q;
      if (in_ok && !out_ok)
        cnt_b_q <= cnt_b_q + 2'd1;
      else if (out_ok && !in_ok)
        cnt_b_q <= cnt_b_q - 2'd1;
    end
  end
endmodule // fcs_node

/* File: sim/fcs_node_assertions.sv */
`timescale 1ns/1ps
module fcs_node_checker #(
  parameter DATA_W = 8
) (
  input wire              CLK_SYS_I,
  input wire              RESET_N_I,
  input wire              CAN_RX_I,
  input wire              CAN_TX_O,
  input wire              RX_VALID_O,
  input wire              RX_READY_I,
  input wire [10:0]       RX_ID_O,
  input wire [DATA_W-1:0] RX_DATA_O,
  input wire              CONNECTED_O,
  input wire              DUP_ADDRESS_O,
  input wire              BUS_OFF_O,
  input wire              STATUS_EVENT_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  busoff_quiet_a: assert property (BUS_OFF_O |-> CAN_TX_O)
    else $error("driving while bus-off");
  busoff_hold_a: assert property (BUS_OFF_O |=> BUS_OFF_O)
    else $error("bus-off left");
  dup_hold_a: assert property (DUP_ADDRESS_O |=> DUP_ADDRESS_O)
    else $error("duplicate flag dropped");
  dup_early_a: assert property ($rose(DUP_ADDRESS_O) |-> !$past(CONNECTED_O))
    else $error("duplicate flagged after connect");
  dup_event_a: assert property ($rose(DUP_ADDRESS_O) |-> STATUS_EVENT_O || $past(STATUS_EVENT_O))
    else $error("no event on duplicate");
  off_event_a: assert property ($rose(BUS_OFF_O) |-> STATUS_EVENT_O || $past(STATUS_EVENT_O))
    else $error("no event on bus-off");
  event_pulse_a: assert property (STATUS_EVENT_O |=> !STATUS_EVENT_O)
    else $error("event longer than one cycle");
  bit_stand_a: assert property ($fell(CAN_TX_O) |=> !CAN_TX_O [*8])
    else $error("dominant bit too short");
  idle_start_a: assert property ($fell(CAN_TX_O) |-> $past(CAN_RX_I, 3))
    else $error("dominant sent over busy bus");
  rx_hold_a: assert property (RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_ID_O)
    && $stable(RX_DATA_O))
    else $error("stalled word changed");
  cover property ($rose(CONNECTED_O));
  cover property ($rose(DUP_ADDRESS_O));
  cover property ($fell(CAN_TX_O));
endmodule // fcs_node_checker

bind fcs_node fcs_node_checker #(.DATA_W(DATA_W)) chk_u (.CLK_SYS_I, .RESET_N_I, .CAN_RX_I,
  .CAN_TX_O, .RX_VALID_O, .RX_READY_I, .RX_ID_O, .RX_DATA_O, .CONNECTED_O, .DUP_ADDRESS_O,
  .BUS_OFF_O, .STATUS_EVENT_O);

/* File: sim/fcs_master_model.sv */
`timescale 1ns/1ps
module fcs_master_model (
  input  wire clk_i,
  input  wire node_tx_i,
  output reg  bus_tx_o
);
  integer i;
  initial bus_tx_o = 1'b1;
  // master only sends standard data frames, msb first
  task send(input [20:0] f);
    begin
      for (i = 20; i >= 0; i = i - 1) begin
        bus_tx_o = f[i];
        repeat (80) @(negedge clk_i);
      end
      bus_tx_o = 1'b1;
    end
  endtask
  // collect a reply sampled mid-bit; master stays recessive meanwhile
  task recv(output [20:0] f);
    begin
      f = 21'h1fffff;
      for (i = 0; i < 4000 && node_tx_i; i = i + 1) @(negedge clk_i);
      repeat (40) @(negedge clk_i);
      for (i = 20; i >= 0; i = i - 1) begin
        f[i] = node_tx_i;
        repeat (80) @(negedge clk_i);
      end
    end
  endtask
endmodule // fcs_master_model

/* File: sim/fcs_node_test.sv */
`timescale 1ns/1ps
module fcs_node_test;
  localparam [5:0] ADDR = 6'h2a;
  reg         clk;
  reg         rst_n;
  reg         rx_ready;
  reg  [7:0]  io_data;
  reg  [1:0]  io_mode;
  reg  [15:0] io_period;
  integer     gap;
  wire        node_tx;
  wire        mst_tx;
  wire        rx_valid;
  wire [10:0] rx_id;
  wire [7:0]  rx_data;
  wire        connected;
  wire        dup;
  wire        bus_off;
  wire        evt;
  reg  [20:0] frm;
  integer     err_count;
  integer     tests_run;
  integer     cycles;

  fcs_node #(.DATA_W(8)) dut_u (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .CAN_RX_I(mst_tx & node_tx), .CAN_TX_O(node_tx), .NODE_ADDRESS_I(ADDR),
    .IO_MODE_I(io_mode), .IO_PERIOD_BITS_I(io_period), .IO_DATA_I(io_data),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .RX_ID_O(rx_id), .RX_DATA_O(rx_data),
    .CONNECTED_O(connected), .DUP_ADDRESS_O(dup), .BUS_OFF_O(bus_off),
    .STATUS_EVENT_O(evt));
  fcs_master_model mst_u (.clk_i(clk), .node_tx_i(node_tx), .bus_tx_o(mst_tx));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  task chk(input [20:0] got, input [20:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task stop_test;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task msg(input [10:0] id, input [7:0] d);
    begin
      mst_u.send({1'b0, id, d, 1'b0});
      repeat (40) @(negedge clk);
    end
  endtask

  task t_dup;
    begin
      msg({2'b10, ADDR, 3'h7}, 8'h00);
      chk(dup, 1'b1);
      repeat (3000) @(negedge clk);
    end
  endtask

  task t_connect;
    begin
      msg({2'b10, ADDR, 3'h6}, 8'h00);
      chk(connected, 1'b1);
      chk(dup, 1'b1);
      repeat (3000) @(negedge clk);
    end
  endtask

  task t_poll;
    begin
      io_data = 8'h5c;
      msg({2'b10, ADDR, 3'h5}, 8'h00);
      mst_u.recv(frm);
      chk(frm, {1'b0, 2'b01, ADDR, 3'h3, 8'h5c, 1'b0});
      repeat (1000) @(negedge clk);
      msg({2'b10, 6'h00, 3'h0}, 8'hff);
      mst_u.recv(frm);
      chk(frm, 21'h1fffff);
    end
  endtask

  // steady period is 64 bits; recv itself spends 1720 clocks of it
  task t_cyclic;
    begin
      io_data = 8'h71;
      io_mode = 2'h2;
      mst_u.recv(frm);
      chk(frm, {1'b0, 2'b01, ADDR, 3'h3, 8'h71, 1'b0});
      mst_u.recv(frm);
      chk(frm, {1'b0, 2'b01, ADDR, 3'h3, 8'h71, 1'b0});
      gap = 0;
      while (node_tx) begin
        @(negedge clk);
        gap = gap + 1;
      end
      chk(gap[20:0], 21'd3400);
      repeat (2000) @(negedge clk);
    end
  endtask

  task t_cos;
    begin
      io_mode = 2'h1;
      io_data = 8'h9e;
      mst_u.recv(frm);
      chk(frm, {1'b0, 2'b01, ADDR, 3'h3, 8'h9e, 1'b0});
      mst_u.recv(frm);
      chk(frm, {1'b0, 2'b01, ADDR, 3'h3, 8'h9e, 1'b0});
      gap = 0;
      while (node_tx) begin
        @(negedge clk);
        gap = gap + 1;
      end
      chk(gap[20:0], 21'd3400);
    end
  endtask

  task t_buffer;
    begin
      rx_ready = 1'b0;
      msg({2'b10, ADDR, 3'h4}, 8'h11);
      repeat (3000) @(negedge clk);
      msg({2'b10, ADDR, 3'h4}, 8'h22);
      repeat (3000) @(negedge clk);
      msg({2'b10, ADDR, 3'h4}, 8'h33);
      repeat (3000) @(negedge clk);
      chk({rx_valid, rx_id, rx_data}, {1'b1, 2'b10, ADDR, 3'h4, 8'h11});
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
      chk({rx_valid, rx_data}, {1'b1, 8'h22});
      rx_ready = 1'b1;
      @(negedge clk);
      chk(rx_valid, 1'b0);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rx_ready = 1'b1;
    io_data = 8'h00;
    io_mode = 2'h0;
    io_period = 16'h0040;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({node_tx, connected, dup, bus_off, evt, rx_valid}, 6'h20);
    t_dup;
    t_connect;
    t_poll;
    t_buffer;
    t_cyclic;
    t_cos;
    stop_test;
  end
endmodule // fcs_node_test
